// >>> verilog/anp_pkg.sv
// Shared constants and types for the next-page and low-power-idle control block.
`default_nettype none

package anp_pkg;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_EEE_ADV = 16'h003c;
  localparam logic [15:0] REG_EEE_LP = 16'h003d;
  localparam logic [15:0] EEE_ADV_RST = 16'h0000;
  localparam logic [15:0] EEE_ADV_ON = 16'h0006;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Field positions and page encodings
  // ---------------------------------------------------------------
  localparam int EEE_1G_BIT = 2;
  localparam int EEE_100_BIT = 1;
  localparam int PAGE_NP_BIT = 15;
  localparam int PAGE_MP_BIT = 13;
  localparam int STRAP_EEE_POS = 4;
  localparam logic [10:0] MSG_GIGABIT = 11'h008;
  localparam logic [10:0] MSG_EEE = 11'h00a;
  localparam logic [3:0] IDLE_LO = 4'h1;
  localparam logic [3:0] IDLE_HI = 4'h0;

  // ---------------------------------------------------------------
  // Times as printed and the cycle counts derived from them
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int QUIET_MS = 20;
  localparam int REFRESH_US = 200;
  localparam int WAKE_1G_US = 16;
  localparam int WAKE_100_US = 30;
  localparam int HOLDOFF_S = 1;
  localparam int QUIET_CYC = QUIET_MS * 1000 * CLK_MHZ;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int WAKE_1G_CYC = WAKE_1G_US * CLK_MHZ;
  localparam int WAKE_100_CYC = WAKE_100_US * CLK_MHZ;
  localparam int HOLDOFF_CYC = HOLDOFF_S * 1000000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ANP_SPD_10 = 2'b00,
    ANP_SPD_100 = 2'b01,
    ANP_SPD_1000 = 2'b10,
    ANP_SPD_RSV = 2'b11
  } anp_speed_e;

  typedef enum logic [2:0] {
    NP_IDLE = 3'b000,
    NP_GB_MSG = 3'b001,
    NP_GB_UF1 = 3'b010,
    NP_GB_UF2 = 3'b011,
    NP_EEE_MSG = 3'b100,
    NP_EEE_UF = 3'b101,
    NP_SW = 3'b110,
    NP_DONE = 3'b111
  } anp_np_state_e;

endpackage

`default_nettype wire

// >>> verilog/anp_tx_idle.sv
// RGMII transmit sampler that recognises the MAC's low-power-idle pattern.
`default_nettype none

module anp_tx_idle
  import anp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // RGMII transmit pins
  input wire logic txc,
  input wire logic tx_ctl,
  input wire logic [3:0] txd,
  // Mode and result
  input wire logic gig_mode,
  output logic mac_idle
);

  // ---------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ---------------------------------------------------------------
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic txc_q;
  logic rise;
  logic fall;
  logic ctl_r;
  logic ctl_f;
  logic [3:0] nib_lo;
  logic [3:0] nib_hi;
  logic idle_now;

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
      txc_q <= 1'b0;
    end else begin
      pin_meta <= {txc, tx_ctl, txd};
      pin_sync <= pin_meta;
      txc_q <= pin_sync[5];
    end
  end

  // Edges of the sampled link clock.
  assign rise = pin_sync[5] & ~txc_q;
  assign fall = ~pin_sync[5] & txc_q;

  // ---------------------------------------------------------------
  // Double-edge capture
  // ---------------------------------------------------------------
  // Enable and low nibble on rising edges, error and high nibble on falling ones.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctl_r <= 1'b1;
      ctl_f <= 1'b0;
      nib_lo <= 4'h0;
      nib_hi <= 4'h0;
    end else begin
      if (rise) begin
        ctl_r <= pin_sync[4];
        nib_lo <= pin_sync[3:0];
      end
      if (fall) begin
        ctl_f <= pin_sync[4];
        nib_hi <= pin_sync[3:0];
      end
    end
  end

  // The high nibble only counts at gigabit; at 100 Mb/s the pattern is one nibble.
  always_comb begin
    idle_now = ~ctl_r & ctl_f & (nib_lo == IDLE_LO) & (~gig_mode | (nib_hi == IDLE_HI));
  end

  // Registered result; with the clock stopped the captures simply hold.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mac_idle <= 1'b0;
    end else begin
      mac_idle <= idle_now;
    end
  end

  AST_IDLE_EXIT_ON_ENABLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rise && pin_sync[4] |=> ##1 !mac_idle)
    else $error("Idle held although transmit enable was sampled high.");

endmodule

`default_nettype wire

// >>> verilog/anp_link_ctrl.sv
// Next-page sequencing, duplex, fast link drop and transmit low-power-idle control.
// Summary of operation
// - Gigabit set: message code 8, two unformatted
// - Unformatted pages: leader/follower control, then seed
// - Store gigabit exchange result in status
// - Gigabit next pages are always sent
// - EEE message code 10 unless override set
// - EEE page sends advertisement, stores partner ability
// - Skip EEE pages when advertisement is zero
// - Software pages follow only if enabled
// - Parallel detect gives half unless forced
// - Enabled fast drop reports via in-band link
// - Gigabit drop: remote status low or unlock
// - 100 Mb/s drop: descrambler unlock only
// - Advertisement bits apply after negotiation restart
// - Idle default comes from mode straps
// - Transmit and receive idle kept separate
// - Refresh 200 us every 20 ms
// - Wake within 16 us or 30 us
// - Hold off idle one second after link
// - Enable/low nibble rising, error/high falling
// - Gigabit idle pattern enters, any change leaves
// - 100 Mb/s idle uses rising nibble only
`default_nettype none

module anp_link_ctrl
  import anp_pkg::*;
#(
  parameter int QUIET_CYCLES = QUIET_CYC,
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Management register port
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  // Straps and control bits
  input wire logic [4:0] mode_strap,
  input wire logic negotiation_restart_trigger,
  input wire logic [15:0] ms_ctrl,
  input wire logic [15:0] ls_seed,
  input wire logic [10:0] eee_msg_override,
  input wire logic adv_np_en,
  input wire logic pd_force_full_100m,
  input wire logic pd_force_full_10m,
  input wire logic fast_link_drop_en,
  input wire logic idle_link_up_holdoff,
  // Next-page exchange
  input wire logic an_np_start,
  output logic np_tx_valid,
  output logic [15:0] np_tx_page,
  input wire logic np_rx_valid,
  input wire logic [15:0] np_rx_page,
  input wire logic sw_np_valid,
  input wire logic [15:0] sw_np_page,
  output logic sw_np_ready,
  output logic np_done,
  // Exchange results
  output logic [15:0] ms_status,
  output logic [15:0] lp_eee_ability,
  // Link state
  input wire anp_speed_e link_speed,
  input wire logic link_up,
  input wire logic pd_link,
  input wire logic an_full_duplex,
  input wire logic remote_rx_ok,
  input wire logic descr_locked,
  output logic duplex_full,
  output logic inband_link_up,
  // RGMII transmit pins
  input wire logic txc,
  input wire logic tx_ctl,
  input wire logic [3:0] txd,
  // Low-power idle
  input wire logic rx_lpi_in,
  output logic tx_lpi_active,
  output logic rx_lpi_active,
  output logic refresh_active,
  output logic tx_wake_busy
);

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  localparam int QW = $clog2(QUIET_CYCLES + 1);
  localparam int HW = $clog2(HOLDOFF_CYCLES + 1);

  // ---------------------------------------------------------------
  // Registers and strap capture
  // ---------------------------------------------------------------
  logic [15:0] eee_advertise;
  logic [15:0] eee_active;
  logic strap_done;
  logic eee_on;

  // Straps are caught on the first cycle after reset; restart copies the live value.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strap_done <= 1'b0;
      eee_advertise <= EEE_ADV_RST;
      eee_active <= EEE_ADV_RST;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      eee_advertise <= mode_strap[STRAP_EEE_POS] ? EEE_ADV_ON : EEE_ADV_RST;
      eee_active <= mode_strap[STRAP_EEE_POS] ? EEE_ADV_ON : EEE_ADV_RST;
    end else begin
      if (mgmt_wr && mgmt_addr == REG_EEE_ADV) begin
        eee_advertise <= mgmt_wdata;
      end
      if (negotiation_restart_trigger) begin
        eee_active <= eee_advertise;
      end
    end
  end

  assign eee_on = (eee_active != EEE_ADV_RST);

  // Read data is registered; unmapped offsets read as zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_addr == REG_EEE_ADV) begin
      mgmt_rdata <= eee_advertise;
    end else if (mgmt_addr == REG_EEE_LP) begin
      mgmt_rdata <= lp_eee_ability;
    end else begin
      mgmt_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Next-page sequencer
  // ---------------------------------------------------------------
  anp_np_state_e np_state;
  anp_np_state_e next_np_state;
  logic [10:0] eee_code;
  logic [15:0] next_page;

  assign eee_code = (eee_msg_override != 11'h000) ? eee_msg_override : MSG_EEE;

  // Each page advances when the partner's answering page arrives.
  always_comb begin
    next_np_state = np_state;
    unique case (np_state)
      NP_IDLE: begin
        if (an_np_start) begin
          next_np_state = NP_GB_MSG;
        end
      end
      NP_GB_MSG: begin
        if (np_rx_valid) begin
          next_np_state = NP_GB_UF1;
        end
      end
      NP_GB_UF1: begin
        if (np_rx_valid) begin
          next_np_state = NP_GB_UF2;
        end
      end
      NP_GB_UF2: begin
        if (np_rx_valid) begin
          next_np_state = eee_on ? NP_EEE_MSG : (adv_np_en ? NP_SW : NP_DONE);
        end
      end
      NP_EEE_MSG: begin
        if (np_rx_valid) begin
          next_np_state = NP_EEE_UF;
        end
      end
      NP_EEE_UF: begin
        if (np_rx_valid) begin
          next_np_state = adv_np_en ? NP_SW : NP_DONE;
        end
      end
      NP_SW: begin
        if (np_rx_valid && sw_np_valid && !sw_np_page[PAGE_NP_BIT]) begin
          next_np_state = NP_DONE;
        end
      end
      NP_DONE: begin
        if (an_np_start) begin
          next_np_state = NP_GB_MSG;
        end
      end
    endcase
    if (negotiation_restart_trigger) begin
      next_np_state = NP_IDLE;
    end
  end

  // Page content for the state being entered; next-page bit marks more to come.
  always_comb begin
    next_page = 16'h0000;
    unique case (next_np_state)
      NP_GB_MSG: begin
        next_page = {1'b1, 1'b0, 1'b1, 2'b00, MSG_GIGABIT};
      end
      NP_GB_UF1: begin
        next_page = {1'b1, 4'h0, ms_ctrl[10:0]};
      end
      NP_GB_UF2: begin
        next_page = {eee_on | adv_np_en, 4'h0, ls_seed[10:0]};
      end
      NP_EEE_MSG: begin
        next_page = {1'b1, 1'b0, 1'b1, 2'b00, eee_code};
      end
      NP_EEE_UF: begin
        next_page = {adv_np_en, 4'h0, eee_active[10:0]};
      end
      NP_SW: begin
        next_page = sw_np_page;
      end
      NP_IDLE, NP_DONE: begin
        next_page = 16'h0000;
      end
    endcase
  end

  // State and page register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      np_state <= NP_IDLE;
      np_tx_page <= 16'h0000;
    end else begin
      np_state <= next_np_state;
      np_tx_page <= next_page;
    end
  end

  // Offered while a page is held; software pages only once software has one.
  assign np_tx_valid = (np_state != NP_IDLE) && (np_state != NP_DONE) && ((np_state != NP_SW) || sw_np_valid);
  assign sw_np_ready = (np_state == NP_SW) && sw_np_valid && np_rx_valid;
  assign np_done = (np_state == NP_DONE);

  // Partner pages that carry results are kept; restart clears them.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || negotiation_restart_trigger) begin
      ms_status <= STATUS_RST;
      lp_eee_ability <= STATUS_RST;
    end else if (np_rx_valid) begin
      if (np_state == NP_GB_UF1) begin
        ms_status <= np_rx_page;
      end
      if (np_state == NP_EEE_UF) begin
        lp_eee_ability <= np_rx_page;
      end
    end
  end

  AST_GB_MSG_CODE: assert property (
    np_state == NP_GB_MSG |-> np_tx_page[10:0] == MSG_GIGABIT && np_tx_page[PAGE_MP_BIT])
    else $error("Gigabit message page does not carry code 8.");

  AST_GB_UF_CONTENT: assert property (
    np_state == NP_GB_UF1 && $stable(ms_ctrl) |-> np_tx_page[10:0] == ms_ctrl[10:0])
    else $error("First gigabit unformatted page lost the control contents.");

  AST_MS_STATUS_STORE: assert property (
    np_state == NP_GB_UF1 && np_rx_valid && !negotiation_restart_trigger |=> ms_status == $past(np_rx_page))
    else $error("Gigabit exchange result not stored.");

  AST_GB_ALWAYS: assert property (
    np_state == NP_IDLE && an_np_start && !negotiation_restart_trigger |=> np_state == NP_GB_MSG ##0 np_tx_valid)
    else $error("Gigabit next pages were not started.");

  AST_EEE_CODE: assert property (
    np_state == NP_EEE_MSG && $stable(eee_msg_override) |->
      np_tx_page[10:0] == ((eee_msg_override != 11'h000) ? eee_msg_override : MSG_EEE))
    else $error("EEE message code is neither 10 nor the override.");

  AST_EEE_SKIP: assert property (
    np_state == NP_GB_UF2 && np_rx_valid && !eee_on |=> np_state != NP_EEE_MSG)
    else $error("EEE pages sent with an empty advertisement.");

  AST_SW_GATED: assert property (
    np_state == NP_EEE_UF && np_rx_valid && !adv_np_en && !negotiation_restart_trigger |=> np_state == NP_DONE)
    else $error("Software pages entered without the next-page bit.");

  // ---------------------------------------------------------------
  // Duplex and fast link drop
  // ---------------------------------------------------------------
  logic fast_link_drop;

  // Parallel-detected links are half duplex unless the per-speed override is set.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      duplex_full <= 1'b0;
    end else if (pd_link) begin
      duplex_full <= (link_speed == ANP_SPD_100 && pd_force_full_100m) ||
                     (link_speed == ANP_SPD_10 && pd_force_full_10m);
    end else begin
      duplex_full <= an_full_duplex;
    end
  end

  // Drop is seen in one cycle, well inside the millisecond budget.
  always_comb begin
    fast_link_drop = 1'b0;
    if (fast_link_drop_en) begin
      if (link_speed == ANP_SPD_1000) begin
        fast_link_drop = !remote_rx_ok || !descr_locked;
      end else if (link_speed == ANP_SPD_100) begin
        fast_link_drop = !descr_locked;
      end
    end
  end

  // Link bit of the in-band status.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      inband_link_up <= 1'b0;
    end else begin
      inband_link_up <= link_up && !fast_link_drop;
    end
  end

  AST_PD_DUPLEX: assert property (
    pd_link && link_speed == ANP_SPD_100 && !pd_force_full_100m |=> !duplex_full)
    else $error("Parallel-detected 100 Mb/s link not half duplex.");

  AST_DROP_1G: assert property (
    fast_link_drop_en && link_speed == ANP_SPD_1000 && !remote_rx_ok |=> !inband_link_up)
    else $error("Gigabit remote status low did not drop the link bit.");

  AST_DROP_100: assert property (
    fast_link_drop_en && link_speed == ANP_SPD_100 && link_up && descr_locked |=> inband_link_up)
    else $error("100 Mb/s link dropped while descrambler locked.");

  // ---------------------------------------------------------------
  // Low-power idle: hold-off, entry, refresh and wake
  // ---------------------------------------------------------------
  logic mac_idle;
  logic [HW-1:0] holdoff_cnt;
  logic holdoff_done;
  logic speed_eee;
  logic [QW-1:0] quiet_cnt;
  logic [8:0] wake_cnt;

  anp_tx_idle u_tx_idle (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .txc(txc),
    .tx_ctl(tx_ctl),
    .txd(txd),
    .gig_mode(link_speed == ANP_SPD_1000),
    .mac_idle(mac_idle)
  );

  // Idle is allowed only where both ends advertised it for the current speed.
  always_comb begin
    speed_eee = 1'b0;
    if (link_speed == ANP_SPD_1000) begin
      speed_eee = eee_active[EEE_1G_BIT] && lp_eee_ability[EEE_1G_BIT];
    end else if (link_speed == ANP_SPD_100) begin
      speed_eee = eee_active[EEE_100_BIT] && lp_eee_ability[EEE_100_BIT];
    end
  end

  // One-second wait after link up before any idle is sent.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !link_up) begin
      holdoff_cnt <= '0;
    end else if (holdoff_cnt != HW'(HOLDOFF_CYCLES)) begin
      holdoff_cnt <= holdoff_cnt + HW'(1);
    end
  end

  assign holdoff_done = !idle_link_up_holdoff || (holdoff_cnt == HW'(HOLDOFF_CYCLES));

  // Transmit and receive idle states are tracked on their own.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_lpi_active <= 1'b0;
      rx_lpi_active <= 1'b0;
    end else begin
      tx_lpi_active <= mac_idle && link_up && holdoff_done && speed_eee;
      rx_lpi_active <= rx_lpi_in && link_up && speed_eee;
    end
  end

  // Quiet for the period, with the refresh burst filling its last part.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !tx_lpi_active) begin
      quiet_cnt <= '0;
      refresh_active <= 1'b0;
    end else begin
      quiet_cnt <= (quiet_cnt == QW'(QUIET_CYCLES - 1)) ? '0 : quiet_cnt + QW'(1);
      refresh_active <= (quiet_cnt >= QW'(QUIET_CYCLES - REFRESH_CYC - 1)) &&
                        (quiet_cnt != QW'(QUIET_CYCLES - 1));
    end
  end

  // Wake time is held busy just under the wake budget after leaving idle; nothing is dropped meanwhile.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_cnt <= 9'h000;
    end else if (tx_lpi_active && !mac_idle) begin
      wake_cnt <= (link_speed == ANP_SPD_1000) ? 9'(WAKE_1G_CYC - 1) : 9'(WAKE_100_CYC - 1);
    end else if (wake_cnt != 9'h000) begin
      wake_cnt <= wake_cnt - 9'h001;
    end
  end

  assign tx_wake_busy = (wake_cnt != 9'h000);

  AST_HOLDOFF: assert property (
    idle_link_up_holdoff && tx_lpi_active |-> $past(holdoff_cnt) == HW'(HOLDOFF_CYCLES))
    else $error("Idle entered before the link-up hold-off ended.");

  AST_REFRESH_START: assert property (
    tx_lpi_active && quiet_cnt == QW'(QUIET_CYCLES - REFRESH_CYC - 1) |=> refresh_active)
    else $error("Refresh burst did not start at the end of the quiet time.");

  AST_WAKE_BOUND: assert property (
    $fell(tx_lpi_active) && link_speed == ANP_SPD_1000 |-> ##[0:160] !tx_wake_busy)
    else $error("Gigabit wake took longer than sixteen microseconds.");

  AST_RX_SEPARATE: assert property (
    rx_lpi_in && link_up && speed_eee && !mac_idle |=> rx_lpi_active && !tx_lpi_active)
    else $error("Receive idle did not stand apart from transmit idle.");

endmodule

`default_nettype wire

// >>> sim/anp_mac_model.sv
// Behavioural MAC driving the RGMII transmit pins, with optional low-power idle.
`default_nettype none

module anp_mac_model (
  // Mode
  input wire logic lpi,
  input wire logic gig,
  // RGMII transmit pins
  output logic txc,
  output logic tx_ctl,
  output logic [3:0] txd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  logic [3:0] idle_cnt = 4'h0;

  // Pins change midway between edges; after nine idle cycles the clock stops with the pins held low.
  initial begin
    txc = 1'b0;
    tx_ctl = 1'b0;
    txd = 4'h0;
    forever begin
      #200;
      if (lpi && idle_cnt >= 4'h9) begin
        tx_ctl = 1'b0;
        txd = 4'h0;
        #600;
      end else begin
        tx_ctl = !lpi;
        txd = lpi ? 4'h1 : cnt;
        idle_cnt = lpi ? idle_cnt + 4'h1 : 4'h0;
        #200 txc = 1'b1;
        #200 tx_ctl = 1'b1;
        txd = (lpi && gig) ? 4'h0 : ~txd;
        cnt = cnt + 4'h1;
        #200 txc = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// >>> sim/anp_link_ctrl_test.sv
// Self-checking bench for next pages, duplex, fast drop and transmit idle.
`default_nettype none

module anp_link_ctrl_test;
  import anp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, sys_rst = 1'b1, mgmt_wr = 1'b0, negotiation_restart_trigger = 1'b0;
  logic [15:0] mgmt_addr = 16'h0000, mgmt_wdata = 16'h0000, mgmt_rdata, np_tx_page, ms_status, lp_eee_ability;
  logic [4:0] mode_strap = 5'h10;
  logic [15:0] ms_ctrl = 16'h0000, ls_seed = 16'h0abc, np_rx_page = 16'h0000, sw_np_page = 16'h0123;
  logic [10:0] eee_msg_override = 11'h000;
  logic adv_np_en = 1'b0, pd_force_full_100m = 1'b0, pd_force_full_10m = 1'b0, fast_link_drop_en = 1'b0;
  logic idle_link_up_holdoff = 1'b1, an_np_start = 1'b0, np_rx_valid = 1'b0, sw_np_valid = 1'b0;
  logic link_up = 1'b0, pd_link = 1'b1, an_full_duplex = 1'b0, remote_rx_ok = 1'b1, descr_locked = 1'b1;
  logic rx_lpi_in = 1'b0, lpi = 1'b0, gig = 1'b1, txc, tx_ctl;
  logic [3:0] txd;
  logic np_tx_valid, sw_np_ready, np_done, duplex_full, inband_link_up;
  logic tx_lpi_active, rx_lpi_active, refresh_active, tx_wake_busy;
  anp_speed_e link_speed = ANP_SPD_1000;
  int n_mismatch = 0, n_checks = 0, i;
  logic [4:0] dup [4] = '{5'b01010, 5'b01101, 5'b00100, 5'b00011};
  logic [5:0] drop [5] = '{6'b110010, 6'b110100, 6'b101011, 6'b101100, 6'b010001};

  anp_link_ctrl #(.QUIET_CYCLES(3000), .HOLDOFF_CYCLES(20)) i_anp_link_ctrl (.ref_clk, .sys_rst, .mgmt_wr,
    .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .mode_strap, .negotiation_restart_trigger, .ms_ctrl, .ls_seed,
    .eee_msg_override, .adv_np_en, .pd_force_full_100m, .pd_force_full_10m, .fast_link_drop_en,
    .idle_link_up_holdoff, .an_np_start, .np_tx_valid, .np_tx_page, .np_rx_valid, .np_rx_page, .sw_np_valid,
    .sw_np_page, .sw_np_ready, .np_done, .ms_status, .lp_eee_ability, .link_speed, .link_up, .pd_link,
    .an_full_duplex, .remote_rx_ok, .descr_locked, .duplex_full, .inband_link_up, .txc, .tx_ctl, .txd,
    .rx_lpi_in, .tx_lpi_active, .rx_lpi_active, .refresh_active, .tx_wake_busy);
  anp_mac_model i_anp_mac_model (.lpi, .gig, .txc, .tx_ctl, .txd);

  // Free-running system clock.
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Moves n edges on and settles just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask

  // Waits a bounded time for a level; a timeout ends the run.
  task automatic await(ref logic s, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && s !== v; k++) tick(1);
    n_checks++;
    if (s !== v) begin
      n_mismatch++;
      $display("[FAIL] %0t wait timed out", $time);
      conclude();
    end
  endtask

  // One-cycle high pulse.
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  // Register write and checked read.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    tick(1);
    mgmt_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    mgmt_addr = a;
    tick(1);
    chk(mgmt_rdata, e);
  endtask

  // Checks the offered page's flag and code bits, then answers it.
  task automatic np_page(input logic [15:0] e, input logic [15:0] rx);
    tick(1);
    await(np_tx_valid, 1'b1, 20);
    chk(np_tx_page & 16'h27ff, e);
    np_rx_page = rx;
    np_rx_valid = 1'b1;
    tick(1);
    np_rx_valid = 1'b0;
  endtask

  // Main sequence.
  initial begin
    tick(8);
    sys_rst = 1'b0;
    tick(2);
    rd(REG_EEE_ADV, EEE_ADV_ON);
    wr(16'h0011, 16'hffff);
    rd(16'h0011, 16'h0000);
    pulse(negotiation_restart_trigger);
    pulse(an_np_start);
    np_page(16'h2008, 16'ha008);
    np_page(16'h0000, 16'h8155);
    np_page(16'h02bc, 16'h8000);
    np_page(16'h200a, 16'ha00a);
    np_page(16'h0006, 16'h0006);
    await(np_done, 1'b1, 20);
    chk(ms_status & 16'h07ff, 16'h0155);
    chk(lp_eee_ability & 16'h07ff, 16'h0006);
    eee_msg_override = 11'h012;
    wr(REG_EEE_ADV, 16'h0000);
    rd(REG_EEE_ADV, 16'h0000);
    pulse(an_np_start);
    np_page(16'h2008, 16'ha008);
    np_page(16'h0000, 16'h8155);
    np_page(16'h02bc, 16'h8000);
    np_page(16'h2012, 16'ha00a);
    np_page(16'h0006, 16'h0006);
    await(np_done, 1'b1, 20);
    lpi = 1'b1;
    tick(40);
    link_up = 1'b1;
    tick(10);
    chk(16'(tx_lpi_active), 16'h0000);
    await(tx_lpi_active, 1'b1, 100);
    chk(16'(rx_lpi_active), 16'h0000);
    chk(16'(refresh_active), 16'h0000);
    await(refresh_active, 1'b1, 4000);
    for (i = 0; i < 3000 && refresh_active === 1'b1; i++) tick(1);
    chk(16'(i), 16'(REFRESH_CYC));
    lpi = 1'b0;
    await(tx_wake_busy, 1'b1, 20);
    for (i = 0; i < 1000 && tx_wake_busy === 1'b1; i++) tick(1);
    chk(16'(i < WAKE_1G_CYC), 16'h0001);
    chk(16'(tx_lpi_active), 16'h0000);
    gig = 1'b0;
    link_speed = ANP_SPD_100;
    lpi = 1'b1;
    rx_lpi_in = 1'b1;
    await(tx_lpi_active, 1'b1, 100);
    chk(16'(rx_lpi_active), 16'h0001);
    lpi = 1'b0;
    rx_lpi_in = 1'b0;
    await(tx_wake_busy, 1'b1, 20);
    for (i = 0; i < 1000 && tx_wake_busy === 1'b1; i++) tick(1);
    chk(16'(i < WAKE_100_CYC), 16'h0001);
    foreach (dup[k]) begin
      link_speed = anp_speed_e'(dup[k][4:3]);
      pd_force_full_100m = dup[k][2];
      pd_force_full_10m = dup[k][1];
      tick(2);
      chk(16'(duplex_full), 16'(dup[k][0]));
    end
    pd_link = 1'b0;
    an_full_duplex = 1'b1;
    tick(2);
    chk(16'(duplex_full), 16'h0001);
    foreach (drop[k]) begin
      fast_link_drop_en = drop[k][5];
      link_speed = anp_speed_e'(drop[k][4:3]);
      remote_rx_ok = drop[k][2];
      descr_locked = drop[k][1];
      tick(2);
      chk(16'(inband_link_up), 16'(drop[k][0]));
    end
    adv_np_en = 1'b1;
    sw_np_valid = 1'b1;
    pulse(negotiation_restart_trigger);
    pulse(an_np_start);
    np_page(16'h2008, 16'ha008);
    np_page(16'h0000, 16'h8155);
    np_page(16'h02bc, 16'h8000);
    tick(1);
    await(np_tx_valid, 1'b1, 20);
    chk(np_tx_page & 16'h27ff, 16'h0123);
    np_rx_page = 16'h0001;
    np_rx_valid = 1'b1;
    #1 chk(16'(sw_np_ready), 16'h0001);
    tick(1);
    np_rx_valid = 1'b0;
    await(np_done, 1'b1, 20);
    chk(lp_eee_ability, 16'h0000);
    conclude();
  end
endmodule

`default_nettype wire
